// ---- rss_cfg.svh ----
// reset sequencer constants
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH
`define RSS_ADDR_CTRL 32'h0000_0000
`define RSS_ADDR_STATUS 32'h0000_0004
`define RSS_ADDR_CAUSE 32'h0000_0008
`define RSS_ADDR_WAIT 32'h0000_000c
`define RSS_CTRL_PDEN_BIT 0
`define RSS_CTRL_WDT_BIT 1
`define RSS_CTRL_STK_BIT 2
`define RSS_PC_RESET 11'h000
`define RSS_SP_RESET 4'h5
`define RSS_LATCH_RESET 4'h0
`define RSS_CNT_RESET 8'h00
`define RSS_MOD_RESET 8'hff
`define RSS_BIT_WDT_LOAD 8'h40
`define RSS_ADC_RESET 8'h00
`define RSS_SYSREG_RESET 4'h0
`define RSS_WAIT_DIV 512
`define RSS_WAIT_COUNTS 256
`define RSS_WAIT_CYCLES (`RSS_WAIT_DIV * `RSS_WAIT_COUNTS)
`endif

// ---- rss_pkg.sv ----
// reset sequencer types
package rss_pkg;
  typedef enum logic [1:0] {
    RSS_SRC_NONE,
    RSS_SRC_COLD,
    RSS_SRC_WARM
  } rss_src_e;
  typedef enum logic [1:0] {
    RSS_ST_RESET,
    RSS_ST_WAIT,
    RSS_ST_RUN
  } rss_state_e;
  typedef struct packed {
    logic [10:0] pc_value;
    logic [3:0] sp_value;
    logic ports_input;
    logic latch_clear;
    logic ctrl_full_init;
    logic timer1_cnt_clear;
    logic bit_wdt_load;
    logic keep_standby_data;
  } rss_init_s;
  typedef struct packed {
    logic [31:0] addr;
    logic valid;
  } rss_ax_s;
endpackage

// ---- rss_reset_sequencer.sv ----
// reset source merge, initial state strobes and stabilization wait
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "rss_cfg.svh"
// Function
// RULE_01 - pin, power, watchdog and stack fault each cause a system reset; code needs wdt_en_r/stk_en_r set for the last two
// RULE_02 - program counter loads zero after every reset
// RULE_03 - all ports input; latches cleared only on pin or power reset
// RULE_04 - data memory kept only for pin/power reset in standby
// RULE_05 - system registers cleared; window register kept only in standby cold reset
// RULE_06 - cold reset: stack pointer 5, timer1 flags set, others cleared, int mirrors pin
// RULE_07 - warm reset: stack pointer 5, int mirrors pin, rest kept
// RULE_08 - cold clears both timer counts; warm clears timer 0 only
// RULE_09 - every reset loads both modulo registers with all ones
// RULE_10 - interval timer counter loads 40 hex on watchdog reset only
// RULE_11 - converter result cleared; shift register kept only in standby cold reset
// RULE_12 - pin release starts oscillator then waits for timer 1
// RULE_13 - wait lasts 512 times 256 clock periods before running
// RULE_14 - watchdog and stack resets skip the wait
// RULE_15 - power-on reset follows the pin reset sequence
// RULE_16 - oscillator stopped while power-on reset holds
// RULE_17 - power-drop reset acts only when enabled by software
// RULE_18 - enabled drop stops oscillator, then waits and restarts at zero
// RULE_19 - power-drop reset held until supply recovers; the cold reset clears pden_r, so the wait starts while the drop persists
// RULE_20 - power-on reset takes precedence over power-drop
// RULE_21 - reset source recorded to pick initial set and wait
// RULE_22 - reset pin release synchronised before counting
module rss_reset_sequencer #(
  parameter int WAIT_CYCLES = `RSS_WAIT_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reset_pin_n,
  input wire logic power_on_det,
  input wire logic power_drop_det,
  input wire logic standby,
  input wire logic int_pin,
  input wire logic wdt_overflow,
  input wire logic stack_fault,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic sys_reset,
  output logic osc_enable,
  output logic cpu_run,
  output logic init_strobe,
  output rss_pkg::rss_init_s init_info,
  output logic [7:0] timer_modulo_value,
  output logic [7:0] converter_result_value,
  output logic int_status,
  output logic power_drop_reset_enable,
  output logic timer1_irq_flag,
  output logic timer1_run_enable,
  output logic interval_timer_irq_flag
);
  import rss_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [1:0] pin_sync_r;
  logic [1:0] por_sync_r;
  logic [1:0] pdd_sync_r;
  logic [1:0] int_sync_r;
  logic [1:0] stby_sync_r;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_sync_r <= 2'b00;
      por_sync_r <= 2'b11;
      pdd_sync_r <= 2'b00;
      int_sync_r <= 2'b00;
      stby_sync_r <= 2'b00;
    end else begin
      pin_sync_r <= {pin_sync_r[0], reset_pin_n}; // RULE_22
      por_sync_r <= {por_sync_r[0], power_on_det};
      pdd_sync_r <= {pdd_sync_r[0], power_drop_det};
      int_sync_r <= {int_sync_r[0], int_pin};
      stby_sync_r <= {stby_sync_r[0], standby};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register bus
  logic pden_r;
  logic wdt_en_r;
  logic stk_en_r;
  logic [31:0] awaddr_r;
  logic aw_have_r;
  logic awready_r;
  logic wready_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_have_r;
  logic bvalid_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [1:0] bresp_r;
  logic wr_fire;
  rss_src_e last_src_r;
  rss_state_e state_r;
  logic [31:0] wait_cnt_r;

  assign wr_fire = aw_have_r && w_have_r && !bvalid_r;

  function automatic logic addr_known(input logic [31:0] a);
    if (a == `RSS_ADDR_CTRL) begin
      addr_known = 1'b1;
    end else if (a == `RSS_ADDR_STATUS) begin
      addr_known = 1'b1;
    end else if (a == `RSS_ADDR_CAUSE) begin
      addr_known = 1'b1;
    end else if (a == `RSS_ADDR_WAIT) begin
      addr_known = 1'b1;
    end else begin
      addr_known = 1'b0;
    end
  endfunction

  always_ff @(posedge clk) begin
    if (!rstn) begin
      aw_have_r <= 1'b0;
      awaddr_r <= 32'h0000_0000;
      w_have_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'b00;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
    end else begin
      // ready outputs are kept as flops that mirror the free slots
      if (s_axi_awvalid && !aw_have_r) begin
        aw_have_r <= 1'b1;
        awready_r <= 1'b0;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_r) begin
        w_have_r <= 1'b1;
        wready_r <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
        bvalid_r <= 1'b1;
        bresp_r <= addr_known(awaddr_r) ? 2'b00 : 2'b10;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // control register; a cold reset clears the enable bits
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pden_r <= 1'b0;
      wdt_en_r <= 1'b0;
      stk_en_r <= 1'b0;
    end else if (state_r == RSS_ST_RESET && last_src_r == RSS_SRC_COLD) begin
      pden_r <= 1'b0; // RULE_06
      wdt_en_r <= 1'b0;
      stk_en_r <= 1'b0;
    end else if (wr_fire && awaddr_r == `RSS_ADDR_CTRL && wstrb_r[0]) begin
      pden_r <= wdata_r[`RSS_CTRL_PDEN_BIT];
      wdt_en_r <= wdata_r[`RSS_CTRL_WDT_BIT];
      stk_en_r <= wdata_r[`RSS_CTRL_STK_BIT];
    end
  end

  // read data for one register word; unmapped words read as zero
  function automatic logic [31:0] read_word(input logic [31:0] a);
    if (a == `RSS_ADDR_CTRL) begin
      read_word = {29'h0, stk_en_r, wdt_en_r, pden_r};
    end else if (a == `RSS_ADDR_STATUS) begin
      read_word = {28'h0, osc_enable, cpu_run, sys_reset, int_status};
    end else if (a == `RSS_ADDR_CAUSE) begin
      read_word = {30'h0, last_src_r};
    end else if (a == `RSS_ADDR_WAIT) begin
      read_word = wait_cnt_r;
    end else begin
      read_word = 32'h0000_0000;
    end
  endfunction

  always_ff @(posedge clk) begin
    if (!rstn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'b00;
    end else begin
      arready_r <= 1'b0;
      if (s_axi_arvalid && !arready_r && !rvalid_r) begin
        arready_r <= 1'b1;
        rvalid_r <= 1'b1;
        rdata_r <= read_word(s_axi_araddr);
        rresp_r <= addr_known(s_axi_araddr) ? 2'b00 : 2'b10;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // source merge and sequencing
  logic cold_req;
  logic warm_req;
  logic wdt_req;
  // power-on overrides the drop enable, drop needs it
  assign cold_req = !pin_sync_r[1] || por_sync_r[1] || (pdd_sync_r[1] && pden_r); // RULE_01 RULE_15 RULE_17 RULE_19 RULE_20
  assign wdt_req = wdt_overflow && wdt_en_r;
  assign warm_req = wdt_req || (stack_fault && stk_en_r); // RULE_01

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= RSS_ST_RESET;
      last_src_r <= RSS_SRC_COLD;
      wait_cnt_r <= 32'h0000_0000;
    end else if (cold_req) begin
      state_r <= RSS_ST_RESET; // RULE_16 RULE_18
      last_src_r <= RSS_SRC_COLD; // RULE_21
      wait_cnt_r <= 32'h0000_0000;
    end else if (warm_req && state_r == RSS_ST_RUN) begin
      state_r <= RSS_ST_RESET;
      last_src_r <= RSS_SRC_WARM; // RULE_21
    end else begin
      case (state_r)
        RSS_ST_RESET: begin
          if (last_src_r == RSS_SRC_COLD) begin
            state_r <= RSS_ST_WAIT; // RULE_12
          end else begin
            state_r <= RSS_ST_RUN; // RULE_14
          end
        end
        RSS_ST_WAIT: begin
          if (wait_cnt_r == 32'(WAIT_CYCLES - 1)) begin
            state_r <= RSS_ST_RUN; // RULE_13
          end
          wait_cnt_r <= wait_cnt_r + 32'h1;
        end
        default: begin
          state_r <= RSS_ST_RUN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  logic wdt_cause_r;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wdt_cause_r <= 1'b0;
    end else if (cold_req) begin
      wdt_cause_r <= 1'b0;
    end else if (warm_req && state_r == RSS_ST_RUN) begin
      wdt_cause_r <= wdt_req;
    end
  end

  // run, oscillator and reset status
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sys_reset <= 1'b1;
      osc_enable <= 1'b0;
      cpu_run <= 1'b0;
      init_strobe <= 1'b0;
      int_status <= 1'b0;
      power_drop_reset_enable <= 1'b0;
    end else begin
      sys_reset <= cold_req || state_r != RSS_ST_RUN;
      // oscillator stays stopped while a pin, power-on or enabled power-drop reset is asserted
      osc_enable <= !cold_req; // RULE_16
      cpu_run <= !cold_req && state_r == RSS_ST_RUN;
      power_drop_reset_enable <= pden_r;
      int_status <= int_sync_r[1]; // RULE_06 RULE_07
      init_strobe <= state_r == RSS_ST_RESET && !cold_req;
    end
  end

  // initial state set handed to the core and peripherals
  always_ff @(posedge clk) begin
    if (!rstn) begin
      init_info <= '0;
    end else begin
      if (state_r == RSS_ST_RESET) begin
        init_info.pc_value <= `RSS_PC_RESET; // RULE_02
        init_info.sp_value <= `RSS_SP_RESET; // RULE_06 RULE_07
        init_info.ports_input <= 1'b1; // RULE_03
        init_info.latch_clear <= last_src_r == RSS_SRC_COLD; // RULE_03
        init_info.ctrl_full_init <= last_src_r == RSS_SRC_COLD; // RULE_05 RULE_06 RULE_07
        init_info.timer1_cnt_clear <= last_src_r == RSS_SRC_COLD; // RULE_08
        init_info.bit_wdt_load <= wdt_cause_r; // RULE_10
        init_info.keep_standby_data <= last_src_r == RSS_SRC_COLD && stby_sync_r[1]; // RULE_04 RULE_11
      end
    end
  end

  // timer, converter and control flag initial values
  always_ff @(posedge clk) begin
    if (!rstn) begin
      timer_modulo_value <= `RSS_MOD_RESET;
      converter_result_value <= `RSS_ADC_RESET;
      timer1_irq_flag <= 1'b1;
      timer1_run_enable <= 1'b1;
      interval_timer_irq_flag <= 1'b0;
    end else begin
      if (state_r == RSS_ST_RESET) begin
        timer_modulo_value <= `RSS_MOD_RESET; // RULE_09
        converter_result_value <= `RSS_ADC_RESET; // RULE_11
        if (last_src_r == RSS_SRC_COLD) begin
          timer1_irq_flag <= 1'b1; // RULE_06
          timer1_run_enable <= 1'b1;
          interval_timer_irq_flag <= 1'b0;
        end
      end
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
endmodule

// ---- rss_reset_sequencer_props.sv ----
// assertions on the reset sequencer ports
`timescale 1ns/1ns
module rss_reset_sequencer_props #(
  parameter int WAIT_CYCLES = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reset_pin_n,
  input wire logic power_on_det,
  input wire logic power_drop_det,
  input wire logic int_pin,
  input wire logic sys_reset,
  input wire logic osc_enable,
  input wire logic cpu_run,
  input wire logic init_strobe,
  input wire rss_pkg::rss_init_s init_info,
  input wire logic [7:0] timer_modulo_value,
  input wire logic [7:0] converter_result_value,
  input wire logic int_status,
  input wire logic power_drop_reset_enable
);
  import rss_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  init_vals_a: assert property (init_strobe |-> init_info.pc_value == 11'h000 &&
    init_info.sp_value == 4'h5 && init_info.ports_input) else $error("initial values wrong");
  cold_set_a: assert property (init_strobe |-> init_info.ctrl_full_init == init_info.latch_clear
    && init_info.timer1_cnt_clear == init_info.latch_clear) else $error("initial set mixed");
  keep_set_a: assert property (init_strobe && init_info.keep_standby_data |-> init_info.latch_clear)
    else $error("standby keep on warm reset");
  cold_wait_a: assert property (init_strobe && init_info.latch_clear |=> !cpu_run [*8])
    else $error("run before wait ends");
  warm_skip_a: assert property (init_strobe && !init_info.latch_clear |-> ##[1:4] cpu_run)
    else $error("warm reset waited");
  pin_hold_a: assert property (!reset_pin_n [*5] |-> sys_reset && !cpu_run && !osc_enable)
    else $error("pin reset not held");
  por_osc_a: assert property (power_on_det [*5] |-> sys_reset && !osc_enable)
    else $error("oscillator runs in power-on");
  drop_rst_a: assert property ($rose(power_drop_det) && power_drop_reset_enable
    |-> ##[1:5] (sys_reset && !osc_enable)) else $error("drop reset missing");
  int_high_a: assert property (int_pin [*6] |-> int_status)
    else $error("int status not high");
  int_low_a: assert property (!int_pin [*6] |-> !int_status)
    else $error("int status not low");
  mod_out_a: assert property ($fell(sys_reset) |-> timer_modulo_value == 8'hff
    && converter_result_value == 8'h00) else $error("modulo or converter wrong");
endmodule
bind rss_reset_sequencer rss_reset_sequencer_props #(.WAIT_CYCLES(WAIT_CYCLES)) props_u (.clk(clk), .rstn(rstn),
  .reset_pin_n(reset_pin_n), .power_on_det(power_on_det), .power_drop_det(power_drop_det), .int_pin(int_pin),
  .sys_reset(sys_reset), .osc_enable(osc_enable), .cpu_run(cpu_run), .init_strobe(init_strobe),
  .init_info(init_info), .timer_modulo_value(timer_modulo_value), .int_status(int_status),
  .converter_result_value(converter_result_value), .power_drop_reset_enable(power_drop_reset_enable));

// ---- rss_supply_model.sv ----
// reset pin circuit and supply monitor model
`timescale 1ns/1ns
module rss_supply_model (
  input wire logic clk,
  input wire logic pin_req,
  input wire logic por_req,
  input wire logic drop_req,
  output logic reset_pin_n,
  output logic power_on_det,
  output logic power_drop_det
);
  initial begin
    reset_pin_n = 1'b1;
    power_on_det = 1'b0;
    power_drop_det = 1'b0;
  end
  always @(posedge clk) begin
    reset_pin_n <= !pin_req;
    power_on_det <= por_req;
    // a rising supply reports power-on only
    power_drop_det <= drop_req && !por_req;
  end
endmodule

// ---- reset_source_sequencer_bench.sv ----
// self-checking bench for the reset sequencer
`timescale 1ns/1ns
module reset_source_sequencer_bench;
  import rss_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, standby = 1'b0, int_pin = 1'b0, wdt = 1'b0, stk = 1'b0;
  logic pin_req = 1'b0, por_req = 1'b0, drop_req = 1'b0, seen_wdt = 1'b0, seen_keep = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin_n, por, drop, sys_reset, osc, run, strobe;
  logic int_status, pd_en, t1_irq, t1_run, it_irq;
  logic [1:0] bresp, rresp, rs;
  logic [7:0] tmod, adc;
  rss_init_s info;
  int failures = 0, total_checks = 0, cyc = 0, n;
  rss_supply_model sup_u (.clk(clk), .pin_req(pin_req), .por_req(por_req), .drop_req(drop_req),
    .reset_pin_n(pin_n), .power_on_det(por), .power_drop_det(drop));
  rss_reset_sequencer #(.WAIT_CYCLES(16)) dut_u (.clk(clk), .rstn(rstn), .reset_pin_n(pin_n),
    .power_on_det(por), .power_drop_det(drop), .standby(standby), .int_pin(int_pin), .wdt_overflow(wdt),
    .stack_fault(stk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sys_reset(sys_reset), .osc_enable(osc), .cpu_run(run), .init_strobe(strobe),
    .init_info(info), .timer_modulo_value(tmod), .converter_result_value(adc), .int_status(int_status),
    .power_drop_reset_enable(pd_en), .timer1_irq_flag(t1_irq), .timer1_run_enable(t1_run),
    .interval_timer_irq_flag(it_irq));
  always #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  task stop_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task rd_reg(input logic [31:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    arvalid <= 1'b0;
    rready <= 1'b0;
  endtask
  // counts cycles until the run state reaches v
  task wait_run(input logic v);
    n = 0;
    while (run !== v && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk(n < 300, 1, "run wait timed out");
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (strobe === 1'b1) begin
      seen_wdt <= info.bit_wdt_load;
      seen_keep <= info.keep_standby_data;
    end
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    wait_run(1);
    chk(n >= 16, 1, "cold wait short");
    chk({t1_irq, t1_run, it_irq, pd_en}, 4'b1100, "cold control bits");
    chk({tmod, adc}, 16'hff00, "modulo or converter");
    rd_reg(32'h8);
    chk(rd, 32'h1, "cause after cold");
    rd_reg(32'h10);
    chk(rs, 2'b10, "unmapped read");
    standby <= 1'b1;
    pin_req <= 1'b1;
    repeat (6) @(posedge clk);
    chk({sys_reset, run, osc}, 3'b100, "pin reset outputs");
    pin_req <= 1'b0;
    wait_run(1);
    chk({n >= 16, seen_keep}, 2'b11, "pin wait or standby keep");
    standby <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      wr(32'h0, 32'h7);
      wdt <= (i == 0);
      stk <= (i == 1);
      @(posedge clk);
      wdt <= 1'b0;
      stk <= 1'b0;
      wait_run(0);
      wait_run(1);
      chk({n <= 4, seen_wdt, pd_en}, {1'b1, i == 0, 1'b1}, "warm reset");
      rd_reg(32'h8);
      chk(rd, 32'h2, "cause after warm");
    end
    drop_req <= 1'b1;
    repeat (6) @(posedge clk);
    chk({sys_reset, osc}, 2'b10, "drop reset");
    drop_req <= 1'b0;
    wait_run(1);
    chk({n >= 16, pd_en}, 2'b10, "drop recovery");
    drop_req <= 1'b1;
    repeat (10) @(posedge clk);
    chk(run, 1'b1, "drop while disabled");
    por_req <= 1'b1;
    repeat (6) @(posedge clk);
    chk({sys_reset, osc}, 2'b10, "power-on hold");
    por_req <= 1'b0;
    drop_req <= 1'b0;
    wait_run(1);
    chk(n >= 16, 1, "power-on wait");
    for (int i = 0; i < 2; i++) begin
      int_pin <= i[0];
      repeat (6) @(posedge clk);
      chk(int_status, i[0], "int status");
    end
    stop_test();
  end
endmodule
